// >>> pmp_regs.svh
`ifndef PMP_REGS_SVH
`define PMP_REGS_SVH

// ==========================================================
// Timing
`define PMP_CLK_PERIOD_NS 8
`define PMP_CLK_KHZ (1000000 / `PMP_CLK_PERIOD_NS)
`define PMP_MII_FAST_KHZ 25000
`define PMP_MII_SLOW_KHZ 2500
`define PMP_RMII_PERIOD_NS 20
`define PMP_RMII_KHZ (1000000 / `PMP_RMII_PERIOD_NS)
`define PMP_RMII_SLOW_REPEAT 10
`define PMP_STRAP_SETTLE 3
`define PMP_ACC_W 18

// ==========================================================
// Receive buffer layout
`define PMP_FIFO_DEPTH 8
`define PMP_FIFO_WIDTH 5
`define PMP_RX_LAST_BIT 4

// ==========================================================
// Strap reset values
`define PMP_STRAP_RMII_RESET 1'b0
`define PMP_STRAP_WOL_RESET 1'b0
`define PMP_STRAP_REF_IN_RESET 1'b0

`endif

// >>> pmp_pkg.sv
package pmp_pkg;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    pmp_mode_mii,
    pmp_reverse_mii_variant,
    pmp_rmii_clock_in_variant,
    pmp_rmii_clock_out_variant
  } pmp_mode_type;

  typedef enum logic {
    pmp_settle,
    pmp_run
  } pmp_phase_type;

endpackage

// >>> pmp_fifo.sv
`timescale 1ns/10ps
`include "pmp_regs.svh"

module pmp_fifo
  import pmp_pkg::*;
#(
  parameter int WIDTH = `PMP_FIFO_WIDTH,
  parameter int DEPTH = `PMP_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  // ==========================================================
  // Handshake
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  assign out_valid = count != '0;

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + CW'(1);
    end else if (pop && !push) begin
      next_count = count - CW'(1);
    end
  end

  // ==========================================================
  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end else if (ce) begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= next_count;
      // Registered from next_count so the source sees full in the same cycle the count reaches it, never overflowing
      in_ready <= next_count != CW'(DEPTH);
    end
  end

endmodule

// >>> pmp_port.sv
`timescale 1ns/10ps
`include "pmp_regs.svh"


module pmp_port
  import pmp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic speed_100,
  input wire logic [3:0] rx_nibble,
  input wire logic rx_last,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [3:0] tx_nibble,
  output logic tx_valid,
  output logic tx_frame,
  output logic strap_done,
  output logic strap_rmii,
  output logic strap_ref_clk_in,
  output logic strap_wol,
  output logic strap_reverse,
  input wire logic rx_dv_in,
  output logic rx_dv_out,
  output logic rx_dv_oe_n,
  input wire logic rxd1_in,
  input wire logic rxd3_in,
  output logic [3:0] rxd_out,
  output logic rxd_oe_n,
  output logic rxc_out,
  input wire logic txc_in,
  output logic txc_out,
  output logic txc_oe_n,
  input wire logic [3:0] txd_in,
  input wire logic tx_en_in
);

  localparam logic [`PMP_ACC_W-1:0] ACC_MOD = `PMP_ACC_W'(`PMP_CLK_KHZ);
  localparam logic [`PMP_ACC_W-1:0] ACC_HALF = `PMP_ACC_W'(`PMP_CLK_KHZ / 2);
  localparam logic [`PMP_ACC_W-1:0] STEP_FAST = `PMP_ACC_W'(`PMP_MII_FAST_KHZ);
  localparam logic [`PMP_ACC_W-1:0] STEP_SLOW = `PMP_ACC_W'(`PMP_MII_SLOW_KHZ);
  localparam logic [`PMP_ACC_W-1:0] STEP_RMII = `PMP_ACC_W'(`PMP_RMII_KHZ);
  localparam logic [3:0] REP_LAST = 4'(`PMP_RMII_SLOW_REPEAT - 1);
  localparam logic [1:0] SETTLE_LAST = 2'(`PMP_STRAP_SETTLE);

  // ==========================================================
  // Pin synchronisers
  logic [8:0] pin_meta;
  logic [8:0] pin_sync;
  logic s_rx_dv;
  logic s_rxd1;
  logic s_rxd3;
  logic s_txc;
  logic s_tx_en;
  logic [3:0] s_txd;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 9'h000;
      pin_sync <= 9'h000;
    end else if (ce) begin
      pin_meta <= {rx_dv_in, rxd1_in, rxd3_in, txc_in, tx_en_in, txd_in};
      pin_sync <= pin_meta;
    end
  end

  assign {s_rx_dv, s_rxd1, s_rxd3, s_txc, s_tx_en, s_txd} = pin_sync;

  // ==========================================================
  // Strap capture
  pmp_phase_type phase;
  pmp_mode_type mode;
  logic [1:0] settle;
  logic take_strap;
  logic is_rmii;
  logic ref_in;

  // Pins pass two flops first, so the straps are read a few cycles after release
  assign take_strap = (phase == pmp_settle) && (settle == SETTLE_LAST);
  assign is_rmii = (mode == pmp_rmii_clock_in_variant) || (mode == pmp_rmii_clock_out_variant);
  assign ref_in = (mode == pmp_rmii_clock_in_variant);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= pmp_settle;
      settle <= 2'h0;
    end else if (ce) begin
      case (phase)
        pmp_settle: begin
          if (settle == SETTLE_LAST) begin
            phase <= pmp_run;
          end else begin
            settle <= settle + 2'h1;
          end
        end
        pmp_run: begin
          phase <= pmp_run;
        end
        default: begin
          phase <= pmp_settle;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= pmp_mode_mii;
      strap_done <= 1'b0;
      strap_rmii <= `PMP_STRAP_RMII_RESET;
      strap_ref_clk_in <= `PMP_STRAP_REF_IN_RESET;
      strap_wol <= `PMP_STRAP_WOL_RESET;
      strap_reverse <= 1'b0;
    end else if (ce && take_strap) begin
      strap_done <= 1'b1;
      strap_rmii <= s_rx_dv;
      strap_wol <= s_rxd1;
      strap_ref_clk_in <= s_rx_dv && s_rxd3;
      strap_reverse <= !s_rx_dv && s_rxd3;
      case ({s_rx_dv, s_rxd3})
        2'h0: mode <= pmp_mode_mii;
        2'h1: mode <= pmp_reverse_mii_variant;
        2'h2: mode <= pmp_rmii_clock_out_variant;
        2'h3: mode <= pmp_rmii_clock_in_variant;
        default: mode <= pmp_mode_mii;
      endcase
    end
  end

  // ==========================================================
  // Line clock generation
  // A phase accumulator gives the exact mean rate; 50 MHz from 125 MHz
  // comes out with 2/3-cycle jitter, the price of having a single clock.
  logic [`PMP_ACC_W-1:0] acc;
  logic [`PMP_ACC_W-1:0] step;
  logic [`PMP_ACC_W-1:0] next_acc;
  logic gen_clk;
  logic next_gen;
  logic [1:0] gen_dly;

  always_comb begin
    step = speed_100 ? STEP_FAST : STEP_SLOW;
    if (is_rmii) begin
      step = STEP_RMII;
    end
    next_acc = acc + step;
    if (next_acc >= ACC_MOD) begin
      next_acc = next_acc - ACC_MOD;
    end
    next_gen = next_acc >= ACC_HALF;
  end

  // Only clk feeds these dividers, so MDC never enters the line timing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
      gen_clk <= 1'b0;
      gen_dly <= 2'h0;
      rxc_out <= 1'b0;
      txc_out <= 1'b0;
      txc_oe_n <= 1'b1;
    end else if (ce && phase == pmp_run) begin
      acc <= next_acc;
      gen_clk <= next_gen;
      gen_dly <= {gen_dly[0], gen_clk};
      rxc_out <= !is_rmii && next_gen;
      txc_out <= !ref_in && next_gen;
      txc_oe_n <= ref_in;
    end
  end

  // ==========================================================
  // Link edges
  // An input reference is only seen through the synchroniser; the local
  // clock is delayed by the same two cycles so transmit sampling lines up.
  logic lvl_tx;
  logic lvl_rx;
  logic lvl_tx_q;
  logic lvl_rx_q;
  logic tx_tick;
  logic rx_tick;

  assign lvl_tx = ref_in ? s_txc : gen_dly[1];
  assign lvl_rx = ref_in ? s_txc : gen_clk;
  assign tx_tick = (phase == pmp_run) && lvl_tx && !lvl_tx_q;
  assign rx_tick = (phase == pmp_run) && !lvl_rx && lvl_rx_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_tx_q <= 1'b0;
      lvl_rx_q <= 1'b0;
    end else if (ce) begin
      lvl_tx_q <= lvl_tx;
      lvl_rx_q <= lvl_rx;
    end
  end

  // ==========================================================
  // Receive path
  logic [`PMP_FIFO_WIDTH-1:0] f_data;
  logic f_valid;
  logic rx_take;
  logic rx_half;
  logic rx_gap;
  logic [3:0] rx_rep;

  pmp_fifo #(
    .WIDTH(`PMP_FIFO_WIDTH),
    .DEPTH(`PMP_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_data({rx_last, rx_nibble}),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(rx_take)
  );

  always_comb begin
    rx_take = 1'b0;
    if (rx_tick && rx_rep == 4'h0 && !rx_gap && f_valid) begin
      rx_take = !is_rmii || rx_half;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_dv_oe_n <= 1'b1;
      rxd_oe_n <= 1'b1;
    end else if (ce && take_strap) begin
      rx_dv_oe_n <= 1'b0;
      rxd_oe_n <= 1'b0;
    end
  end

  // Outputs move on the falling edge, half a period ahead of the MAC's sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_dv_out <= 1'b0;
      rxd_out <= 4'h0;
      rx_half <= 1'b0;
      rx_gap <= 1'b0;
      rx_rep <= 4'h0;
    end else if (ce && rx_tick) begin
      if (rx_rep != 4'h0) begin
        rx_rep <= rx_rep - 4'h1;
      end else begin
        rx_rep <= (is_rmii && !speed_100) ? REP_LAST : 4'h0;
        if (rx_gap || !f_valid) begin
          rx_dv_out <= 1'b0;
          rx_half <= 1'b0;
          rx_gap <= 1'b0;
        end else if (!is_rmii) begin
          rxd_out <= f_data[3:0];
          rx_dv_out <= 1'b1;
          rx_gap <= f_data[`PMP_RX_LAST_BIT];
        end else if (!rx_half) begin
          rxd_out <= {2'h0, f_data[1:0]};
          rx_dv_out <= 1'b1;
          rx_half <= 1'b1;
        end else begin
          rxd_out <= {2'h0, f_data[3:2]};
          rx_half <= 1'b0;
          rx_gap <= f_data[`PMP_RX_LAST_BIT];
        end
      end
    end
  end

  // ==========================================================
  // Transmit path
  // Only enable and data are sampled; there is no transmit-error pin.
  logic tx_half;
  logic [1:0] tx_low;
  logic [3:0] tx_rep;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_nibble <= 4'h0;
      tx_valid <= 1'b0;
      tx_frame <= 1'b0;
      tx_half <= 1'b0;
      tx_low <= 2'h0;
      tx_rep <= 4'h0;
    end else if (ce) begin
      tx_valid <= 1'b0;
      if (tx_tick) begin
        tx_frame <= s_tx_en;
        if (!s_tx_en) begin
          tx_half <= 1'b0;
          tx_rep <= 4'h0;
        end else if (tx_rep != 4'h0) begin
          tx_rep <= tx_rep - 4'h1;
        end else if (!is_rmii) begin
          tx_nibble <= s_txd;
          tx_valid <= 1'b1;
        end else begin
          tx_rep <= speed_100 ? 4'h0 : REP_LAST;
          if (!tx_half) begin
            tx_low <= s_txd[1:0];
            tx_half <= 1'b1;
          end else begin
            tx_nibble <= {s_txd[1:0], tx_low};
            tx_valid <= 1'b1;
            tx_half <= 1'b0;
          end
        end
      end
    end
  end

endmodule

// >>> pmp_port_sva.sv
`timescale 1ns/10ps
module pmp_port_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic speed_100,
  input wire logic strap_done,
  input wire logic strap_rmii,
  input wire logic strap_ref_clk_in,
  input wire logic strap_wol,
  input wire logic strap_reverse,
  input wire logic rx_dv_out,
  input wire logic rx_dv_oe_n,
  input wire logic rxd_oe_n,
  input wire logic [3:0] rxd_out,
  input wire logic rxc_out,
  input wire logic txc_oe_n,
  input wire logic tx_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ========
  // Straps and pad direction
  a_pads_released: assert property (!strap_done |-> rx_dv_oe_n && rxd_oe_n
    && txc_oe_n) else $error("pad driven early");
  a_pads_driven: assert property (strap_done |-> !rx_dv_oe_n && !rxd_oe_n)
    else $error("pad not driven");
  a_straps_frozen: assert property ($past(strap_done) |-> strap_done
    && $stable({strap_rmii, strap_wol, strap_ref_clk_in, strap_reverse}))
    else $error("strap moved");
  a_ref_in_rmii: assert property (strap_ref_clk_in |-> strap_rmii)
    else $error("ref input outside rmii");
  a_reverse_mii: assert property (strap_reverse |-> !strap_rmii)
    else $error("reverse in rmii");
  a_ref_dir_in: assert property (strap_ref_clk_in |-> txc_oe_n)
    else $error("txc driven");
  a_ref_dir_out: assert property ($past(strap_done, 2) && !strap_ref_clk_in |-> !txc_oe_n)
    else $error("txc not driven");
  // ========
  // Line clocks
  a_rmii_quiet: assert property (strap_rmii |-> !rxc_out && rxd_out[3:2] == 2'b00)
    else $error("rmii extra lines");
  a_fast_rxc: assert property (!strap_rmii && speed_100 && $rose(rxc_out)
    |-> ##[1:4] !rxc_out) else $error("rxc too slow");
  a_slow_rxc: assert property (!strap_rmii && !speed_100 && $rose(rxc_out)
    |-> rxc_out[*8]) else $error("rxc too fast");
  a_tx_pulse: assert property (tx_valid |=> !tx_valid)
    else $error("tx pulse long");
  c_rmii_in: cover property (strap_done && strap_ref_clk_in);
  c_reverse: cover property (strap_done && strap_reverse);
  c_frame_end: cover property ($fell(rx_dv_out));
  c_tx_rmii: cover property (tx_valid && strap_rmii);
endmodule

bind pmp_port pmp_port_sva u_sva (.clk, .rst_n, .speed_100, .strap_done, .strap_rmii,
  .strap_ref_clk_in, .strap_wol, .strap_reverse, .rx_dv_out, .rx_dv_oe_n, .rxd_oe_n,
  .rxd_out, .rxc_out, .txc_oe_n, .tx_valid);

// >>> pmp_mac_model.sv
`timescale 1ns/10ps
module pmp_mac_model (
  input wire logic link_clk,
  input wire logic rmii,
  input wire logic slow,
  input wire logic start,
  output logic [3:0] txd,
  output logic tx_en
);
  // ========
  // Frame source: twelve nibbles, nibble k is k*5+9
  int k = 0;
  int rep = 0;
  logic hi = 1'b0;
  logic [3:0] n;
  initial begin
    txd = 4'h0;
    tx_en = 1'b0;
  end
  // Launch on the falling edge so the rising edge finds settled pins
  always @(negedge link_clk) begin
    n = 4'(k * 5 + 9);
    if (start && k < 12) begin
      tx_en <= 1'b1;
      txd <= rmii ? {2'b00, hi ? n[3:2] : n[1:0]} : n;
      rep <= (rmii && slow && rep < 9) ? rep + 1 : 0;
      if (!(rmii && slow && rep < 9)) begin
        hi <= rmii && !hi;
        if (!rmii || hi) k <= k + 1;
      end
    end else begin
      tx_en <= 1'b0;
      // Idle data is junk so a stale nibble cannot pass
      txd <= ~txd;
      if (!start) k <= 0;
      if (!start) hi <= 1'b0;
      if (!start) rep <= 0;
    end
  end
endmodule

// >>> pmp_port_tb.sv
`timescale 1ns/10ps
module pmp_port_tb;
  import pmp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic speed_100 = 1'b1;
  logic [3:0] rx_nibble = 4'h0;
  logic rx_last = 1'b0;
  logic rx_valid = 1'b0;
  logic ref_clk = 1'b0;
  logic s_dv = 1'b0, s_d1 = 1'b0, s_d3 = 1'b0, go = 1'b0, rxc_q = 1'b0, txc_q = 1'b0;
  logic rx_ready, tx_valid, tx_frame, strap_done, strap_rmii, strap_ref_clk_in, strap_wol;
  logic strap_reverse, rx_dv_out, rx_dv_oe_n, rxd_oe_n, rxc_out, txc_out, txc_oe_n, tx_en_in;
  logic rx_dv_in, rxd1_in, rxd3_in, txc_in;
  logic [3:0] tx_nibble, rxd_out, txd_in;
  logic [3:0] rq[$], tq[$];
  logic [1:0] dq[$];
  int err_count = 0, checked = 0, seed = 66, nr = 0, nt = 0, stall = 0;

  always #4 clk = ~clk;
  always #40 ref_clk = ~ref_clk;
  // ========
  // Pads: released strap pins show the strap level; a released txc shows ref_clk when strapped for clock in, else the pull-down
  assign rx_dv_in = rx_dv_oe_n ? s_dv : rx_dv_out;
  assign rxd1_in = rxd_oe_n ? s_d1 : rxd_out[1];
  assign rxd3_in = rxd_oe_n ? s_d3 : rxd_out[3];
  assign txc_in = txc_oe_n ? (s_dv && s_d3 && ref_clk) : txc_out;

  pmp_port u_dut (.clk, .rst_n, .ce(1'b1), .speed_100, .rx_nibble, .rx_last, .rx_valid,
    .rx_ready, .tx_nibble, .tx_valid, .tx_frame, .strap_done, .strap_rmii, .strap_ref_clk_in,
    .strap_wol, .strap_reverse, .rx_dv_in, .rx_dv_out, .rx_dv_oe_n, .rxd1_in, .rxd3_in,
    .rxd_out, .rxd_oe_n, .rxc_out, .txc_in, .txc_out, .txc_oe_n, .txd_in, .tx_en_in);
  pmp_mac_model u_mac (.link_clk(txc_in), .rmii(s_dv), .slow(!speed_100), .start(go),
    .txd(txd_in), .tx_en(tx_en_in));

  // ========
  // Monitor: the MAC takes receive data on the rising link clock
  // Looked at on the falling clk edge, where the design's flops have settled
  always @(negedge clk) begin
    rxc_q <= rxc_out;
    txc_q <= txc_in;
    if (rxc_out && !rxc_q) nr++;
    if (txc_in && !txc_q) nt++;
    if (rxc_out && !rxc_q && rx_dv_out) rq.push_back(rxd_out);
    if (tx_valid) tq.push_back(tx_nibble);
  end
  // An input reference rises on a falling clk edge, half way between rising edges, so no race here
  always @(posedge ref_clk) begin
    if (strap_ref_clk_in && rx_dv_out) dq.push_back(rxd_out[1:0]);
  end

  task conclude;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task bail;
    err_count++;
    conclude();
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) err_count++;
    if (got !== exp) $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  // Line clocks come from an accumulator, so allow one edge of slack
  task near(input int got, input int exp);
    checked++;
    if (got < exp - 1 || got > exp + 1) err_count++;
    if (got < exp - 1 || got > exp + 1) $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
  endtask

  function automatic logic [1:0] dibit(input logic [3:0] n, input int upper);
    return (upper != 0) ? n[3:2] : n[1:0];
  endfunction

  task start_mode(input logic dv, input logic d3, input logic spd);
    int w;
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    s_dv = dv;
    s_d3 = d3;
    s_d1 = 1'($random(seed));
    speed_100 = spd;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (w = 0; strap_done !== 1'b1 && w < 20; w++) @(posedge clk);
    if (w >= 20) bail();
    repeat (3) @(posedge clk);
    #1;
    chk({strap_rmii, strap_ref_clk_in, strap_wol, strap_reverse}, {dv, dv & d3, s_d1, !dv & d3});
    chk({1'b0, rx_dv_oe_n, rxd_oe_n, txc_oe_n}, {3'b000, dv & d3});
  endtask

  task push(input logic [3:0] n, input logic l);
    int w;
    rx_nibble = n;
    rx_last = l;
    rx_valid = 1'b1;
    @(posedge clk);
    for (w = 0; rx_ready !== 1'b1 && w < 500; w++) begin
      stall++;
      @(posedge clk);
    end
    if (w >= 500) bail();
    #1;
  endtask

  task rx_burst;
    logic [3:0] sent[$];
    int w;
    int r;
    // The queue is static, so a later burst must not see the last one's nibbles
    sent.delete();
    stall = 0;
    rq.delete();
    dq.delete();
    r = speed_100 ? 1 : 10;
    for (int i = 0; i < 12; i++) begin
      sent.push_back(4'($random(seed)));
      push(sent[i], i == 11);
    end
    rx_valid = 1'b0;
    for (w = 0; (strap_rmii ? dq.size() < 24 * r : rq.size() < 12) && w < 4000; w++)
      @(posedge clk);
    if (w >= 4000) bail();
    repeat (100) @(posedge clk);
    if (strap_rmii) begin
      chk({3'b000, dq.size() == 24 * r}, 4'h1);
      for (int j = 0; j < 24 * r; j++) begin
        chk({2'b00, dq[j]}, {2'b00, dibit(sent[j / (2 * r)], (j / r) % 2)});
      end
    end else begin
      foreach (sent[i]) chk(rq[i], sent[i]);
    end
    chk({3'b000, rx_dv_out}, 4'h0);
    if (!speed_100) chk({3'b000, stall > 0}, 4'h1);
    #1;
  endtask

  task tx_burst;
    int w;
    tq.delete();
    go = 1'b1;
    for (w = 0; tq.size() < 12 && w < 4000; w++) @(posedge clk);
    if (w >= 4000) bail();
    #1;
    go = 1'b0;
    for (int i = 0; i < 12; i++) chk(tq[i], 4'(i * 5 + 9));
  endtask

  initial begin
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        start_mode(m[1], m[0], s[0]);
        nr = 0;
        nt = 0;
        repeat (500) @(posedge clk);
        near(nr, m[1] ? 0 : (s ? 100 : 10));
        if (m != 3) near(nt, m[1] ? 200 : (s ? 100 : 10));
        #1;
        // Not with the local 50 MHz reference: its jitter leaves no clean MAC sampling edge
        if (m != 2) rx_burst();
        tx_burst();
        $display("test mode %0d speed %0d done", m, s);
      end
    end
    conclude();
  end
endmodule
